// >>> inc/lsc_defines.vh
// register map, field positions and reset values of the regulator control bank
// assumes a 16-bit register address and 16-bit data
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH

// register addresses
`define LSC_A_R1_ON        16'h4069
`define LSC_A_R1_SLEEP     16'h406A
`define LSC_A_R2_CTRL      16'h406B
`define LSC_A_R2_ON        16'h406C
`define LSC_A_R2_SLEEP     16'h406D
`define LSC_A_IRQ_STAT     16'h40F0
`define LSC_A_IRQ_MASK     16'h40F1

// common field positions
`define LSC_F_SLOT_HI      15
`define LSC_F_SLOT_LO      13
`define LSC_F_MODE         8
`define LSC_F_VSEL_HI      4
`define LSC_F_VSEL_LO      0

// second regulator control word fields
`define LSC_F_ERR_HI       15
`define LSC_F_ERR_LO       14
`define LSC_F_SRC_HI       12
`define LSC_F_SRC_LO       11
`define LSC_F_VPICK        10
`define LSC_F_HMODE_HI     9
`define LSC_F_HMODE_LO     8
`define LSC_F_FLOAT        7
`define LSC_F_SWITCH       6
`define LSC_F_LPVAR        0

// reset values
`define LSC_RST_SLOT       3'h0
`define LSC_RST_SLP_MODE   1'h1
`define LSC_RST_ON_MODE    1'h0
`define LSC_RST_VSEL       5'h00
`define LSC_RST_ERR        2'h0
`define LSC_RST_SRC        2'h0
`define LSC_RST_VPICK      1'h0
`define LSC_RST_HMODE      2'h2
`define LSC_RST_BIT        1'h0
`define LSC_RST_IRQ        2'h0

// encodings
`define LSC_SLOT_TRANS5    3'h0
`define LSC_SLOT_TRANS3    3'h6
`define LSC_SLOT_TRANS1    3'h7
`define LSC_SLOT_HWEN1     3'h6
`define LSC_SLOT_HWEN2     3'h7
`define LSC_ERR_IGNORE     2'h0
`define LSC_ERR_REG_OFF    2'h1
`define LSC_ERR_SYS_RESET  2'h2
`define LSC_ERR_RESERVED   2'h3
`define LSC_SRC_NONE       2'h0
`define LSC_SRC_HCTL1      2'h1
`define LSC_SRC_HCTL2      2'h2
`define LSC_SRC_EITHER     2'h3
`define LSC_HMODE_OFF      2'h1
`define LSC_HMODE_FOLLOW   2'h3

// interrupt status bits
`define LSC_IRQ_UV         0
`define LSC_IRQ_SLEEP      1
`define LSC_F_IRQ_HI       1
`define LSC_F_IRQ_LO       0

// voltage code table, millivolts
`define LSC_V_FINE_MAX     5'h0E
`define LSC_V_COARSE_MIN   5'h0F
`define LSC_V_FINE_BASE    12'h384
`define LSC_V_FINE_STEP    12'h032
`define LSC_V_COARSE_BASE  12'h6A4
`define LSC_V_COARSE_STEP  12'h064

`endif

// >>> testbench/lsc_regs_asserts.sv
// checker for the regulator control bank, bound to lsc_regs
// assumes it sees only the top module ports, one clock domain
`timescale 1ns/100ps
`include "lsc_defines.vh"
module lsc_regs_asserts (
   input wire        CLK_I,
   input wire        RST_B_I,
   input wire [15:0] ADDR_I,
   input wire [15:0] WDATA_I,
   input wire        WR_I,
   input wire        RD_I,
   input wire [15:0] RDATA_O,
   input wire        SLP_SEQ_I,
   input wire        SLOT_STB_I,
   input wire        UV_FAULT_I,
   input wire        REG1_SLP_APPLY_O,
   input wire        REG1_SLP_OFF_O,
   input wire        REG1_SLP_LP_O,
   input wire        REG2_LP_O,
   input wire        REG2_LP20_O,
   input wire        REG2_FLOAT_O,
   input wire        REG2_SWITCH_O,
   input wire        SYS_RST_REQ_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   // decoded bus cycles; derived outputs trail a write by two edges
   wire wr_ctrl = WR_I && ADDR_I == `LSC_A_R2_CTRL;
   wire rd_ctrl = RD_I && ADDR_I == `LSC_A_R2_CTRL;
   wire wr_slp  = WR_I && ADDR_I == `LSC_A_R1_SLEEP;

   float_bit_a: assert property (
      wr_ctrl |-> ##2 REG2_FLOAT_O == $past(WDATA_I[7], 2)) else $error("float bit wrong");
   switch_bit_a: assert property (
      wr_ctrl |-> ##2 REG2_SWITCH_O == $past(WDATA_I[6], 2)) else $error("switch bit wrong");
   sleep_mode_a: assert property (
      wr_slp |-> ##2 REG1_SLP_LP_O == $past(WDATA_I[8], 2)) else $error("sleep mode wrong");
   ctrl_readback_a: assert property (
      wr_ctrl ##1 rd_ctrl |=> RDATA_O[13:0] == ($past(WDATA_I[13:0], 2) & 14'h1FC1))
      else $error("control readback wrong");
   err_reserved_a: assert property (
      wr_ctrl && WDATA_I[15:14] == 2'h3 ##1 rd_ctrl |=> RDATA_O[15:14] == 2'h0)
      else $error("reserved action not read as zero");
   rdata_idle_a: assert property (
      !$past(RD_I) |-> RDATA_O == 16'h0000) else $error("read data outside read slot");
   sys_reset_a: assert property (
      SYS_RST_REQ_O |-> $past(UV_FAULT_I) && !$past(UV_FAULT_I, 2))
      else $error("reset request without fault edge");
   reset_pulse_a: assert property (
      SYS_RST_REQ_O |=> !SYS_RST_REQ_O) else $error("reset request too long");
   apply_cause_a: assert property (
      REG1_SLP_APPLY_O |-> $past(SLP_SEQ_I && SLOT_STB_I) && !REG1_SLP_OFF_O)
      else $error("sleep apply without strobe");
   off_cause_a: assert property (
      REG1_SLP_OFF_O |-> $past(SLP_SEQ_I && SLOT_STB_I)) else $error("sleep off without strobe");
   lp_variant_a: assert property (
      REG2_LP20_O |-> REG2_LP_O) else $error("20 mA variant outside low power");

   // main scenarios reached
   cover property (REG1_SLP_APPLY_O);
   cover property (REG1_SLP_OFF_O);
   cover property (SYS_RST_REQ_O);
endmodule

bind lsc_regs lsc_regs_asserts u_lsc_regs_asserts (.*);

// >>> testbench/testbench.sv
// self-checking bench for the regulator control bank
// assumes lsc_regs with its checker bound; one 250 MHz clock
`timescale 1ns/100ps
`include "lsc_defines.vh"
module testbench;
   logic        CLK_I = 1'h0;
   logic        RST_B_I = 1'h0;
   logic        WR_I = 1'h0;
   logic        RD_I = 1'h0;
   logic        SLP_SEQ_I = 1'h0;
   logic        SLOT_STB_I = 1'h0;
   logic        HCTL1_I = 1'h0;
   logic        HCTL2_I = 1'h0;
   logic        UV_FAULT_I = 1'h0;
   logic [15:0] ADDR_I = 16'h0000;
   logic [15:0] WDATA_I = 16'h0000;
   logic [2:0]  SLOT_NUM_I = 3'h0;
   wire  [15:0] RDATA_O;
   wire  [11:0] REG1_SLP_MV_O;
   wire  [11:0] REG2_MV_O;
   wire         REG1_SLP_APPLY_O, REG1_SLP_OFF_O, REG1_SLP_LP_O, REG2_HCTL_ACT_O;
   wire         REG2_OFF_O, REG2_LP_O, REG2_LP20_O, REG2_FLOAT_O, REG2_SWITCH_O;
   wire         SYS_RST_REQ_O, IRQ_O;
   logic [15:0] exp_q[$];
   logic [15:0] d, r;
   logic        rd_d = 1'h0, act, off, lp;
   integer      error_cnt = 0, tests_run = 0, cyc = 0, seed = 39651, i, s, h;

   lsc_regs u_lsc_regs (.*);

   // free-running clock
   always #2 CLK_I = ~CLK_I;

   // count and report at once
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // verdict, reached from the main sequence or the hang guard
   task results;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // bus write; strobe stays up until the next driver call
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      @(posedge CLK_I);
      ADDR_I  <= a;
      WDATA_I <= v;
      WR_I    <= 1'h1;
      RD_I    <= 1'h0;
   endtask

   // bus read; expected data noted for the monitor
   task automatic rd(input logic [15:0] a, input logic [15:0] v);
      @(posedge CLK_I);
      ADDR_I <= a;
      RD_I   <= 1'h1;
      WR_I   <= 1'h0;
      exp_q.push_back(v);
   endtask

   // idle cycles with every strobe low
   task automatic idle(input integer n);
      repeat (n) begin
         @(posedge CLK_I);
         WR_I       <= 1'h0;
         RD_I       <= 1'h0;
         SLOT_STB_I <= 1'h0;
      end
   endtask

   // one timeslot strobe; the pulses stand only in the next cycle
   task automatic strobe(input integer n, input logic [1:0] e);
      @(posedge CLK_I);
      SLOT_STB_I <= 1'h1;
      SLOT_NUM_I <= n[2:0];
      WR_I       <= 1'h0;
      RD_I       <= 1'h0;
      @(posedge CLK_I);
      SLOT_STB_I <= 1'h0;
      #1 chk({REG1_SLP_APPLY_O, REG1_SLP_OFF_O}, e);
   endtask

   // millivolts of a voltage code
   function automatic logic [15:0] mv(input integer c);
      mv = (c <= 14) ? 16'h0384 + 16'h0032 * c : 16'h06A4 + 16'h0064 * (c - 15);
   endfunction

   // timeslot of a sleep slot code
   function automatic integer sl(input integer c);
      sl = (c == 0) ? 5 : (c == 6) ? 3 : (c == 7) ? 1 : 6 - c;
   endfunction

   // read data monitor: oldest note against the cycle after the strobe
   always @(posedge CLK_I) begin
      rd_d <= RD_I;
      if (rd_d)
         chk(RDATA_O, exp_q.pop_front());
   end

   // hang guard, about twenty times the expected run
   always @(posedge CLK_I) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end

   // main sequence
   initial begin
      repeat (3) @(posedge CLK_I);
      RST_B_I <= 1'h1;
      rd(`LSC_A_R1_SLEEP, 16'h0100);
      rd(`LSC_A_R2_CTRL, 16'h0200);
      rd(16'h4000, 16'h0000);
      idle(2);
      #1 chk(REG1_SLP_MV_O, mv(0));
      chk(REG1_SLP_LP_O, 1'h1);
      $display("reset values test done");
      // every sleep voltage code, random other bits
      for (i = 0; i < 32; i++) begin
         d = $random(seed);
         d[4:0] = i[4:0];
         wr(`LSC_A_R1_SLEEP, d);
         rd(`LSC_A_R1_SLEEP, d & 16'hE11F);
         idle(2);
         #1 chk(REG1_SLP_MV_O, mv(i));
         chk(REG1_SLP_LP_O, d[8]);
      end
      // random control words; reserved action reads back as zero
      for (i = 0; i < 16; i++) begin
         d = $random(seed);
         wr(`LSC_A_R2_CTRL, d);
         rd(`LSC_A_R2_CTRL, d & ((d[15:14] == 2'h3) ? 16'h1FC1 : 16'hDFC1));
         idle(2);
         #1 chk({REG2_FLOAT_O, REG2_SWITCH_O}, d[7:6]);
      end
      $display("voltage and readback test done");
      // sleep slots, plain and under hardware enable; first one refused
      wr(`LSC_A_IRQ_MASK, 16'h0002);
      rd(`LSC_A_IRQ_MASK, 16'h0002);
      idle(1);
      strobe(5, 2'h0);
      for (h = 0; h < 2; h++) begin
         wr(`LSC_A_R1_ON, h ? 16'hC000 : 16'h0000);
         rd(`LSC_A_R1_ON, h ? 16'hC000 : 16'h0000);
         SLP_SEQ_I <= 1'h1;
         for (i = 0; i < 8; i++) begin
            wr(`LSC_A_R1_SLEEP, {i[2:0], 13'h0000});
            idle(2);
            for (s = 1; s < 6; s++)
               strobe(s, (s != sl(i)) ? 2'h0 : (h || i == 0 || i > 5) ? 2'h2 : 2'h1);
         end
      end
      #1 chk(IRQ_O, 1'h1);
      wr(`LSC_A_IRQ_MASK, 16'h0000);
      idle(1);
      #1 chk(IRQ_O, 1'h0);
      rd(`LSC_A_IRQ_STAT, 16'h0002);
      rd(`LSC_A_IRQ_STAT, 16'h0000);
      SLP_SEQ_I <= 1'h0;
      $display("sleep slot test done");
      // undervoltage under ignore, shutdown and system reset
      wr(`LSC_A_IRQ_MASK, 16'h0001);
      for (i = 0; i < 3; i++) begin
         wr(`LSC_A_R2_CTRL, {i[1:0], 14'h0200});
         idle(2);
         UV_FAULT_I <= 1'h1;
         @(posedge CLK_I);
         #1 chk({SYS_RST_REQ_O, IRQ_O}, {i == 2, 1'h1});
         @(posedge CLK_I);
         UV_FAULT_I <= 1'h0;
         #1 chk(REG2_OFF_O, i == 1);
         rd(`LSC_A_IRQ_STAT, 16'h0001);
         idle(1);
         #1 chk(IRQ_O, 1'h0);
      end
      $display("undervoltage test done");
      // hardware control: source, voltage pick, mode, variant
      wr(`LSC_A_R2_SLEEP, 16'h001F);
      rd(`LSC_A_R2_SLEEP, 16'h001F);
      for (i = 0; i < 64; i++) begin
         r = $random(seed);
         d = {3'h0, i[1:0], i[2], i[4:3], 7'h00, i[5]};
         wr(`LSC_A_R2_ON, {7'h00, r[2], 8'h05});
         wr(`LSC_A_R2_CTRL, d);
         rd(`LSC_A_R2_ON, {7'h00, r[2], 8'h05});
         HCTL1_I <= r[0];
         HCTL2_I <= r[1];
         idle(4);
         act = (d[12:11] == 2'h1) ? r[0] : (d[12:11] == 2'h2) ? r[1] :
               (d[12:11] == 2'h3) && (r[0] || r[1]);
         off = act && d[9:8] == 2'h1;
         lp = !act ? r[2] : (d[9:8] == 2'h3) ? r[2] : !off;
         #1 chk({REG2_HCTL_ACT_O, REG2_OFF_O}, {act, off});
         if (!off) begin
            chk({REG2_LP_O, REG2_LP20_O}, {lp, lp && d[0]});
            chk(REG2_MV_O, (act && d[10]) ? mv(31) : mv(5));
         end
      end
      $display("hardware control test done");
      idle(2);
      results();
   end
endmodule

// >>> verilog/lsc_regs.v
// control registers for two linear regulators: sleep entry of the first,
// general control of the second, with undervoltage handling and interrupt
// assumes the sequencer, hardware control inputs and fault are synchronous
`timescale 1ns/100ps
`include "lsc_defines.vh"

// Operation
// - slot codes 000/110/111 transition in 5/3/1
// - codes 001..101 disable in slots 5..1
// - hardware-enabled regulator: those codes enter sleep
// - bit 8 sleep mode, resets to low power
// - codes 00h..0Eh give 0.90..1.60 V
// - codes 0Fh..1Fh give 1.70..3.30 V
// - error action: ignore, regulator off, system reset
// - undervoltage always sets its status bit; it raises the interrupt only when mask bit 0 is set
// - hardware control source: none, 1, 2, either
// - hardware control picks on or sleep voltage
// - hardware mode: low power, off, follow
// - bit 7: discharge or float when disabled
// - bit 0: 50 mA or 20 mA low power
// - on slot 110/111 means hardware enable
// - on mode bit: normal or low power
module lsc_regs (
   input  wire        CLK_I,
   input  wire        RST_B_I,
   input  wire [15:0] ADDR_I,
   input  wire [15:0] WDATA_I,
   input  wire        WR_I,
   input  wire        RD_I,
   output reg  [15:0] RDATA_O,
   input  wire        SLP_SEQ_I,
   input  wire        SLOT_STB_I,
   input  wire [2:0]  SLOT_NUM_I,
   input  wire        HCTL1_I,
   input  wire        HCTL2_I,
   input  wire        UV_FAULT_I,
   output reg         REG1_SLP_APPLY_O,
   output reg         REG1_SLP_OFF_O,
   output reg         REG1_SLP_LP_O,
   output wire [11:0] REG1_SLP_MV_O,
   output reg         REG2_HCTL_ACT_O,
   output reg         REG2_OFF_O,
   output reg         REG2_LP_O,
   output reg         REG2_LP20_O,
   output reg         REG2_FLOAT_O,
   output reg         REG2_SWITCH_O,
   output wire [11:0] REG2_MV_O,
   output reg         SYS_RST_REQ_O,
   output wire        IRQ_O
);

   // register fields
   reg  [2:0] r1_on_slot_r;
   reg        r1_on_mode_r;
   reg  [2:0] r1_slp_slot_r;
   reg        r1_slp_mode_r;
   reg  [4:0] r1_slp_vsel_r;
   reg  [1:0] r2_err_r;
   reg  [1:0] r2_src_r;
   reg        r2_vpick_r;
   reg  [1:0] r2_hmode_r;
   reg        r2_float_r;
   reg        r2_switch_r;
   reg        r2_lpvar_r;
   reg        r2_on_mode_r;
   reg  [4:0] r2_on_vsel_r;
   reg  [4:0] r2_slp_vsel_r;
   reg  [1:0] irq_stat_r;
   reg  [1:0] irq_mask_r;
   reg        uv_prev_r;
   reg        uv_latch_r;

   reg  [15:0] rdata_nxt;
   reg  [1:0]  irq_set;
   reg         r1_hw_en;
   reg         r1_slot_hit;
   reg         r1_trans_code;
   reg         hctl_act;
   reg  [4:0]  r2_vsel_pick;

   wire wr_r1_on   = WR_I & (ADDR_I == `LSC_A_R1_ON);
   wire wr_r1_slp  = WR_I & (ADDR_I == `LSC_A_R1_SLEEP);
   wire wr_r2_ctl  = WR_I & (ADDR_I == `LSC_A_R2_CTRL);
   wire wr_r2_on   = WR_I & (ADDR_I == `LSC_A_R2_ON);
   wire wr_r2_slp  = WR_I & (ADDR_I == `LSC_A_R2_SLEEP);
   wire wr_mask    = WR_I & (ADDR_I == `LSC_A_IRQ_MASK);
   wire rd_stat    = RD_I & (ADDR_I == `LSC_A_IRQ_STAT);
   wire uv_rise    = UV_FAULT_I & ~uv_prev_r;

   // sleep slot code to the timeslot it acts in
   function [2:0] slot_of;
      input [2:0] code;
      begin
         case (code)
            3'h0:    slot_of = 3'h5;
            3'h1:    slot_of = 3'h5;
            3'h2:    slot_of = 3'h4;
            3'h3:    slot_of = 3'h3;
            3'h4:    slot_of = 3'h2;
            3'h5:    slot_of = 3'h1;
            3'h6:    slot_of = 3'h3;
            default: slot_of = 3'h1;
         endcase
      end
   endfunction

   // is the hardware control source currently asserted
   function hctl_on;
      input [1:0] src;
      input       h1;
      input       h2;
      begin
         case (src)
            `LSC_SRC_HCTL1:  hctl_on = h1;
            `LSC_SRC_HCTL2:  hctl_on = h2;
            `LSC_SRC_EITHER: hctl_on = h1 | h2;
            default:         hctl_on = 1'b0;
         endcase
      end
   endfunction

   // sleep slot decision for the first regulator
   always @* begin
      r1_hw_en      = (r1_on_slot_r == `LSC_SLOT_HWEN1) |
                      (r1_on_slot_r == `LSC_SLOT_HWEN2);
      r1_trans_code = (r1_slp_slot_r == `LSC_SLOT_TRANS5) |
                      (r1_slp_slot_r == `LSC_SLOT_TRANS3) |
                      (r1_slp_slot_r == `LSC_SLOT_TRANS1);
      r1_slot_hit   = SLP_SEQ_I & SLOT_STB_I &
                      (SLOT_NUM_I == slot_of(r1_slp_slot_r));
   end

   // second regulator selection under hardware control
   always @* begin
      hctl_act     = hctl_on(r2_src_r, HCTL1_I, HCTL2_I);
      r2_vsel_pick = (hctl_act & r2_vpick_r) ? r2_slp_vsel_r
                                            : r2_on_vsel_r;
   end

   // events that set sticky status
   always @* begin
      irq_set                = 2'h0;
      irq_set[`LSC_IRQ_UV]    = uv_rise;
      irq_set[`LSC_IRQ_SLEEP] = r1_slot_hit;
   end

   // register writes; a reserved error action is stored as ignore
   always @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         r1_on_slot_r  <= `LSC_RST_SLOT;
         r1_on_mode_r  <= `LSC_RST_ON_MODE;
         r1_slp_slot_r <= `LSC_RST_SLOT;
         r1_slp_mode_r <= `LSC_RST_SLP_MODE;
         r1_slp_vsel_r <= `LSC_RST_VSEL;
         r2_err_r      <= `LSC_RST_ERR;
         r2_src_r      <= `LSC_RST_SRC;
         r2_vpick_r    <= `LSC_RST_VPICK;
         r2_hmode_r    <= `LSC_RST_HMODE;
         r2_float_r    <= `LSC_RST_BIT;
         r2_switch_r   <= `LSC_RST_BIT;
         r2_lpvar_r    <= `LSC_RST_BIT;
         r2_on_mode_r  <= `LSC_RST_ON_MODE;
         r2_on_vsel_r  <= `LSC_RST_VSEL;
         r2_slp_vsel_r <= `LSC_RST_VSEL;
         irq_mask_r    <= `LSC_RST_IRQ;
      end else begin
         if (wr_r1_on) begin
            r1_on_slot_r <= WDATA_I[`LSC_F_SLOT_HI:`LSC_F_SLOT_LO];
            r1_on_mode_r <= WDATA_I[`LSC_F_MODE];
         end
         if (wr_r1_slp) begin
            r1_slp_slot_r <= WDATA_I[`LSC_F_SLOT_HI:`LSC_F_SLOT_LO];
            r1_slp_mode_r <= WDATA_I[`LSC_F_MODE];
            r1_slp_vsel_r <= WDATA_I[`LSC_F_VSEL_HI:`LSC_F_VSEL_LO];
         end
         if (wr_r2_ctl) begin
            if (WDATA_I[`LSC_F_ERR_HI:`LSC_F_ERR_LO] == `LSC_ERR_RESERVED) begin
               r2_err_r <= `LSC_ERR_IGNORE;
            end else begin
               r2_err_r <= WDATA_I[`LSC_F_ERR_HI:`LSC_F_ERR_LO];
            end
            r2_src_r    <= WDATA_I[`LSC_F_SRC_HI:`LSC_F_SRC_LO];
            r2_vpick_r  <= WDATA_I[`LSC_F_VPICK];
            r2_hmode_r  <= WDATA_I[`LSC_F_HMODE_HI:`LSC_F_HMODE_LO];
            r2_float_r  <= WDATA_I[`LSC_F_FLOAT];
            r2_switch_r <= WDATA_I[`LSC_F_SWITCH];
            r2_lpvar_r  <= WDATA_I[`LSC_F_LPVAR];
         end
         if (wr_r2_on) begin
            r2_on_mode_r <= WDATA_I[`LSC_F_MODE];
            r2_on_vsel_r <= WDATA_I[`LSC_F_VSEL_HI:`LSC_F_VSEL_LO];
         end
         if (wr_r2_slp) begin
            r2_slp_vsel_r <= WDATA_I[`LSC_F_VSEL_HI:`LSC_F_VSEL_LO];
         end
         if (wr_mask) begin
            irq_mask_r <= WDATA_I[`LSC_F_IRQ_HI:`LSC_F_IRQ_LO];
         end
      end
   end

   // read mux; unassigned bits are zero
   always @* begin
      rdata_nxt = 16'h0000;
      case (ADDR_I)
         `LSC_A_R1_ON: begin
            rdata_nxt[`LSC_F_SLOT_HI:`LSC_F_SLOT_LO] = r1_on_slot_r;
            rdata_nxt[`LSC_F_MODE]                 = r1_on_mode_r;
         end
         `LSC_A_R1_SLEEP: begin
            rdata_nxt[`LSC_F_SLOT_HI:`LSC_F_SLOT_LO] = r1_slp_slot_r;
            rdata_nxt[`LSC_F_MODE]                 = r1_slp_mode_r;
            rdata_nxt[`LSC_F_VSEL_HI:`LSC_F_VSEL_LO] = r1_slp_vsel_r;
         end
         `LSC_A_R2_CTRL: begin
            rdata_nxt[`LSC_F_ERR_HI:`LSC_F_ERR_LO]   = r2_err_r;
            rdata_nxt[`LSC_F_SRC_HI:`LSC_F_SRC_LO]   = r2_src_r;
            rdata_nxt[`LSC_F_VPICK]                = r2_vpick_r;
            rdata_nxt[`LSC_F_HMODE_HI:`LSC_F_HMODE_LO] = r2_hmode_r;
            rdata_nxt[`LSC_F_FLOAT]                = r2_float_r;
            rdata_nxt[`LSC_F_SWITCH]               = r2_switch_r;
            rdata_nxt[`LSC_F_LPVAR]                = r2_lpvar_r;
         end
         `LSC_A_R2_ON: begin
            rdata_nxt[`LSC_F_MODE]                 = r2_on_mode_r;
            rdata_nxt[`LSC_F_VSEL_HI:`LSC_F_VSEL_LO] = r2_on_vsel_r;
         end
         `LSC_A_R2_SLEEP: begin
            rdata_nxt[`LSC_F_VSEL_HI:`LSC_F_VSEL_LO] = r2_slp_vsel_r;
         end
         `LSC_A_IRQ_STAT: rdata_nxt[`LSC_F_IRQ_HI:`LSC_F_IRQ_LO] = irq_stat_r;
         `LSC_A_IRQ_MASK: rdata_nxt[`LSC_F_IRQ_HI:`LSC_F_IRQ_LO] = irq_mask_r;
         default:         rdata_nxt = 16'h0000;
      endcase
   end

   // read data one cycle after the strobe, zero otherwise
   always @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         RDATA_O <= 16'h0000;
      end else begin
         RDATA_O <= RD_I ? rdata_nxt : 16'h0000;
      end
   end

   // sticky status: a new event wins over the clear-on-read
   always @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         irq_stat_r <= `LSC_RST_IRQ;
      end else if (rd_stat) begin
         irq_stat_r <= irq_set;
      end else begin
         irq_stat_r <= irq_stat_r | irq_set;
      end
   end

   assign IRQ_O = |(irq_stat_r & irq_mask_r);

   // undervoltage action; the regulator stays off until its control is rewritten
   always @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         uv_prev_r     <= 1'b0;
         uv_latch_r    <= 1'b0;
         SYS_RST_REQ_O <= 1'b0;
      end else begin
         uv_prev_r     <= UV_FAULT_I;
         SYS_RST_REQ_O <= uv_rise & (r2_err_r == `LSC_ERR_SYS_RESET);
         if (uv_rise & (r2_err_r == `LSC_ERR_REG_OFF)) begin
            uv_latch_r <= 1'b1;
         end else if (wr_r2_ctl) begin
            uv_latch_r <= 1'b0;
         end
      end
   end

   // first regulator sleep actions, one-cycle pulses at the matching slot
   always @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         REG1_SLP_APPLY_O <= 1'b0;
         REG1_SLP_OFF_O   <= 1'b0;
         REG1_SLP_LP_O    <= `LSC_RST_SLP_MODE;
      end else begin
         REG1_SLP_APPLY_O <= r1_slot_hit & (r1_trans_code | r1_hw_en);
         REG1_SLP_OFF_O   <= r1_slot_hit & ~r1_trans_code & ~r1_hw_en;
         REG1_SLP_LP_O    <= r1_slp_mode_r;
      end
   end

   // second regulator operating state
   always @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         REG2_HCTL_ACT_O <= 1'b0;
         REG2_OFF_O     <= 1'b0;
         REG2_LP_O      <= 1'b0;
         REG2_LP20_O    <= 1'b0;
         REG2_FLOAT_O   <= 1'b0;
         REG2_SWITCH_O  <= 1'b0;
      end else begin
         REG2_HCTL_ACT_O <= hctl_act;
         REG2_OFF_O     <= uv_latch_r |
                           (hctl_act & (r2_hmode_r == `LSC_HMODE_OFF));
         if (hctl_act) begin
            REG2_LP_O   <= (r2_hmode_r == `LSC_HMODE_FOLLOW) ? r2_on_mode_r
                                                             : 1'b1;
            REG2_LP20_O <= r2_lpvar_r &
                           ((r2_hmode_r == `LSC_HMODE_FOLLOW) ? r2_on_mode_r
                                                              : 1'b1);
         end else begin
            REG2_LP_O   <= r2_on_mode_r;
            REG2_LP20_O <= r2_lpvar_r & r2_on_mode_r;
         end
         REG2_FLOAT_O   <= r2_float_r;
         REG2_SWITCH_O  <= r2_switch_r;
      end
   end

   // voltage decoders, registered
   lsc_vdec u_vdec_r1 (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .code_i  (r1_slp_vsel_r),
      .mv_o    (REG1_SLP_MV_O)
   );

   lsc_vdec u_vdec_r2 (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .code_i  (r2_vsel_pick),
      .mv_o    (REG2_MV_O)
   );

endmodule

// >>> verilog/lsc_vdec.v
// voltage code to millivolt decoder, registered output
// assumes codes are stable for a cycle; result follows one clock later
`timescale 1ns/100ps
`include "lsc_defines.vh"

module lsc_vdec (
   input  wire        clk_i,
   input  wire        rst_b_i,
   input  wire [4:0]  code_i,
   output reg  [11:0] mv_o
);

   reg  [11:0] mv_nxt;
   wire [11:0] code_w = {7'h00, code_i};

   // two linear segments: fine steps below, coarse steps above
   always @* begin
      if (code_i <= `LSC_V_FINE_MAX) begin
         mv_nxt = `LSC_V_FINE_BASE + code_w * `LSC_V_FINE_STEP;
      end else begin
         mv_nxt = `LSC_V_COARSE_BASE
                + (code_w - {7'h00, `LSC_V_COARSE_MIN}) * `LSC_V_COARSE_STEP;
      end
   end

   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mv_o <= `LSC_V_FINE_BASE;
      end else begin
         mv_o <= mv_nxt;
      end
   end

endmodule
